/* File: hdl/bat_ob_window.sv */
// One outbound window: range check and address substitution.
// Assumes base/top describe a power-of-two window, so top-base is an offset mask.
`timescale 1ns/10ps
module bat_ob_window #(
    parameter int AW = 48,
    parameter int PW = 64
) (
    input wire logic enable_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [AW-1:0] outbound_window_base_i,
    input wire logic [AW-1:0] outbound_window_top_i,
    input wire logic [PW-1:0] outbound_translation_value_i,
    output logic hit_o,
    output logic is64_o,
    output logic [PW-1:0] pcie_addr_o
);
    // ==========================================================
    // Match and translate
    wire [AW-1:0] span = outbound_window_top_i - outbound_window_base_i;
    wire [PW-1:0] off_mask = {{(PW-AW){1'b0}}, span};
    wire [PW-1:0] addr_ext = {{(PW-AW){1'b0}}, addr_i};

    assign hit_o = enable_i && (addr_i >= outbound_window_base_i) && (addr_i <= outbound_window_top_i);
    assign pcie_addr_o = (outbound_translation_value_i & ~off_mask) | (addr_ext & off_mask);
    // Wide address only when the upper half carries something
    assign is64_o = |outbound_translation_value_i[PW-1:32];
endmodule

/* File: hdl/bat_top.sv */
// Address translation unit: outbound window translation, inbound BAR translation, APB registers.
// Assumes requesters on clk_i; one request per cycle, answered one cycle later.
//
// Functional notes
// - A hit window whose translation upper half is non-zero yields a 64-bit PCIe address.
// - A hit window whose translation upper half is zero yields a 32-bit PCIe address.
// - Outbound address keeps the window offset and takes the translation value above it.
// - Inbound address keeps the BAR offset and takes the BAR translation value above it.
// - A 64-bit BAR uses the next odd BAR as its upper half and that BAR stops working alone.
// - Outbound and inbound settings are independent of each other.
// - An outbound address outside every window is answered with a slave error.
// - Up to six outbound windows exist, each mapping to 32-bit or 64-bit space.
// - Outbound translation values are writable at run time.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module bat_top
    import bat_pkg::*;
#(
    parameter int OUTBOUND_WINDOW_COUNT = 6,
    parameter int INBOUND_WINDOW_COUNT = 6
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [bat_pkg::BAT_APB_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic ob_req_valid_i,
    input wire logic [bat_pkg::BAT_AXI_AW-1:0] ob_req_addr_i,
    output logic ob_rsp_valid_o,
    output logic [bat_pkg::BAT_PCIE_AW-1:0] ob_rsp_addr_o,
    output logic ob_rsp_is64_o,
    output logic ob_rsp_slverr_o,
    output logic [2:0] ob_rsp_window_o,
    input wire logic ib_req_valid_i,
    input wire logic [2:0] ib_req_bar_i,
    input wire logic [bat_pkg::BAT_PCIE_AW-1:0] ib_req_addr_i,
    output logic ib_rsp_valid_o,
    output logic [bat_pkg::BAT_AXI_AW-1:0] ib_rsp_addr_o,
    output logic ib_rsp_err_o
);
    import bat_pkg::*;

    function automatic logic [31:0] bat_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Register storage
    logic [BAT_AXI_AW-1:0] ob_base_q [BAT_MAX_WIN];
    logic [BAT_AXI_AW-1:0] ob_top_q [BAT_MAX_WIN];
    logic [BAT_PCIE_AW-1:0] ob_trans_q [BAT_MAX_WIN];
    logic [BAT_PCIE_AW-1:0] ib_trans_q [BAT_MAX_WIN];
    logic [BAT_IB_SIZE_W-1:0] ib_size_q [BAT_MAX_WIN];
    logic [BAT_MAX_WIN-1:0] ib_is64_q;
    logic [BAT_MAX_WIN-1:0] ob_en_q;
    logic [BAT_MAX_WIN-1:0] ib_en_q;
    logic [2:0] last_win_q;
    logic last_is64_q;
    logic miss_q;
    logic [15:0] miss_cnt_q;
    logic [31:0] prdata_q;

    // ==========================================================
    // APB decode
    wire apb_setup = psel_i && !penable_i;
    wire apb_wr = ce_i && psel_i && penable_i && pwrite_i;
    wire ob_sel = paddr_i[11:8] == BAT_OB_REGION;
    wire [2:0] ob_idx = paddr_i[7:5];
    wire [2:0] ob_word = paddr_i[4:2];
    wire ib_sel = (paddr_i[11:8] == BAT_IB_REGION) && !paddr_i[7];
    wire [2:0] ib_idx = paddr_i[6:4];
    wire [1:0] ib_word = paddr_i[3:2];
    wire ctrl_sel = {paddr_i[11:2], 2'b00} == BAT_CTRL_OFS;
    wire stat_sel = {paddr_i[11:2], 2'b00} == BAT_STAT_OFS;
    wire ob_ok = ob_sel && (ob_idx < 3'(BAT_MAX_WIN)) && (ob_word < BAT_OB_W_COUNT);
    wire ib_ok = ib_sel && (ib_idx < 3'(BAT_MAX_WIN));
    wire mapped = ob_ok || ib_ok || ctrl_sel || stat_sel;
    wire [2:0] ob_ri = ob_ok ? ob_idx : 3'h0;
    wire [2:0] ib_ri = ib_ok ? ib_idx : 3'h0;

    wire [31:0] ob_rdata =
        (ob_word == BAT_OB_W_BASE_LO) ? ob_base_q[ob_ri][31:0] :
        (ob_word == BAT_OB_W_BASE_HI) ? {16'h0, ob_base_q[ob_ri][47:32]} :
        (ob_word == BAT_OB_W_TOP_LO) ? ob_top_q[ob_ri][31:0] :
        (ob_word == BAT_OB_W_TOP_HI) ? {16'h0, ob_top_q[ob_ri][47:32]} :
        (ob_word == BAT_OB_W_TRANS_LO) ? ob_trans_q[ob_ri][31:0] : ob_trans_q[ob_ri][63:32];
    wire [31:0] ib_rdata =
        (ib_word == BAT_IB_W_TRANS_LO) ? ib_trans_q[ib_ri][31:0] :
        (ib_word == BAT_IB_W_TRANS_HI) ? ib_trans_q[ib_ri][63:32] :
        (ib_word == BAT_IB_W_SIZE) ? {26'h0, ib_size_q[ib_ri]} : {31'h0, ib_is64_q[ib_ri]};
    wire [31:0] ctrl_rdata = {18'h0, ib_en_q, 2'h0, ob_en_q};
    wire [31:0] stat_rdata = {miss_cnt_q, 7'h0, miss_q, 3'h0, last_is64_q, 1'b0, last_win_q};
    wire [31:0] rd_mux = !mapped ? 32'h0 : ob_ok ? ob_rdata : ib_ok ? ib_rdata : ctrl_sel ? ctrl_rdata : stat_rdata;

    // Read data is fetched in the setup cycle so the access phase needs no wait state
    assign pready_o = ce_i;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o = prdata_q;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prdata_q <= 32'h0;
        end else if (ce_i && apb_setup) begin
            prdata_q <= rd_mux;
        end
    end

    // ==========================================================
    // Per-window registers and outbound matchers
    logic [BAT_MAX_WIN-1:0] ob_hit;
    logic [BAT_MAX_WIN-1:0] ob_is64;
    logic [BAT_PCIE_AW-1:0] ob_paddr [BAT_MAX_WIN];

    for (genvar g = 0; g < BAT_MAX_WIN; g++) begin : g_win
        wire ob_wr = apb_wr && ob_ok && (ob_idx == 3'(g));
        wire ib_wr = apb_wr && ib_ok && (ib_idx == 3'(g));
        wire win_on = ob_en_q[g] && (g < OUTBOUND_WINDOW_COUNT);

        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                ob_base_q[g] <= BAT_ZERO64[BAT_AXI_AW-1:0];
                ob_top_q[g] <= BAT_ZERO64[BAT_AXI_AW-1:0];
                ob_trans_q[g] <= BAT_ZERO64;
            end else if (ob_wr) begin
                case (ob_word)
                    BAT_OB_W_BASE_LO: ob_base_q[g][31:0] <= bat_merge(ob_base_q[g][31:0], pwdata_i, pstrb_i);
                    BAT_OB_W_BASE_HI: ob_base_q[g][47:32] <= 16'(bat_merge({16'h0, ob_base_q[g][47:32]}, pwdata_i, pstrb_i));
                    BAT_OB_W_TOP_LO: ob_top_q[g][31:0] <= bat_merge(ob_top_q[g][31:0], pwdata_i, pstrb_i);
                    BAT_OB_W_TOP_HI: ob_top_q[g][47:32] <= 16'(bat_merge({16'h0, ob_top_q[g][47:32]}, pwdata_i, pstrb_i));
                    BAT_OB_W_TRANS_LO: ob_trans_q[g][31:0] <= bat_merge(ob_trans_q[g][31:0], pwdata_i, pstrb_i);
                    BAT_OB_W_TRANS_HI: ob_trans_q[g][63:32] <= bat_merge(ob_trans_q[g][63:32], pwdata_i, pstrb_i);
                    default: ;
                endcase
            end
        end

        // Inbound settings live in their own registers, untouched by outbound writes
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                ib_trans_q[g] <= BAT_ZERO64;
                ib_size_q[g] <= BAT_IB_SIZE_RST;
                ib_is64_q[g] <= 1'b0;
            end else if (ib_wr) begin
                case (ib_word)
                    BAT_IB_W_TRANS_LO: ib_trans_q[g][31:0] <= bat_merge(ib_trans_q[g][31:0], pwdata_i, pstrb_i);
                    BAT_IB_W_TRANS_HI: ib_trans_q[g][63:32] <= bat_merge(ib_trans_q[g][63:32], pwdata_i, pstrb_i);
                    BAT_IB_W_SIZE: if (pstrb_i[0]) ib_size_q[g] <= pwdata_i[BAT_IB_SIZE_W-1:0];
                    default: if (pstrb_i[0]) ib_is64_q[g] <= pwdata_i[BAT_IB_FLAG_64_POS];
                endcase
            end
        end

        bat_ob_window #(
            .AW(BAT_AXI_AW),
            .PW(BAT_PCIE_AW)
        ) u_win (
            .enable_i(win_on),
            .addr_i(ob_req_addr_i),
            .outbound_window_base_i(ob_base_q[g]),
            .outbound_window_top_i(ob_top_q[g]),
            .outbound_translation_value_i(ob_trans_q[g]),
            .hit_o(ob_hit[g]),
            .is64_o(ob_is64[g]),
            .pcie_addr_o(ob_paddr[g])
        );
    end

    // ==========================================================
    // Control and status
    wire ob_miss = ob_req_valid_i && !(|ob_hit);
    wire miss_clr = apb_wr && stat_sel && pstrb_i[1] && pwdata_i[BAT_STAT_MISS_POS];

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ob_en_q <= BAT_EN_RST;
            ib_en_q <= BAT_EN_RST;
        end else if (apb_wr && ctrl_sel) begin
            if (pstrb_i[0]) ob_en_q <= pwdata_i[BAT_CTRL_OB_EN_POS +: BAT_MAX_WIN];
            if (pstrb_i[1]) ib_en_q <= pwdata_i[BAT_CTRL_IB_EN_POS +: BAT_MAX_WIN];
        end
    end

    // Miss flag: a new miss in the clearing cycle keeps the flag set
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            miss_q <= 1'b0;
            miss_cnt_q <= 16'h0;
        end else if (ce_i) begin
            if (ob_miss) miss_q <= 1'b1;
            else if (miss_clr) miss_q <= 1'b0;
            if (ob_miss && (miss_cnt_q != 16'hffff)) miss_cnt_q <= miss_cnt_q + 16'h1;
        end
    end

    // ==========================================================
    // Outbound selection: lowest numbered hit wins if windows overlap
    logic [2:0] sel_idx;
    always_comb begin
        sel_idx = 3'h0;
        for (int i = BAT_MAX_WIN - 1; i >= 0; i--) begin
            if (ob_hit[i]) sel_idx = 3'(i);
        end
    end
    wire [BAT_PCIE_AW-1:0] sel_paddr = ob_paddr[sel_idx];
    wire sel_is64 = ob_is64[sel_idx];

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ob_rsp_valid_o <= 1'b0;
            ob_rsp_addr_o <= BAT_ZERO64;
            ob_rsp_is64_o <= 1'b0;
            ob_rsp_slverr_o <= 1'b0;
            ob_rsp_window_o <= 3'h0;
            last_win_q <= 3'h0;
            last_is64_q <= 1'b0;
        end else if (ce_i) begin
            ob_rsp_valid_o <= ob_req_valid_i;
            if (ob_req_valid_i) begin
                ob_rsp_slverr_o <= ob_miss;
                ob_rsp_addr_o <= ob_miss ? BAT_ZERO64 : sel_paddr;
                ob_rsp_is64_o <= !ob_miss && sel_is64;
                ob_rsp_window_o <= sel_idx;
                last_win_q <= sel_idx;
                last_is64_q <= !ob_miss && sel_is64;
            end
        end
    end

    // ==========================================================
    // Inbound translation
    wire [2:0] ib_bi = (ib_req_bar_i < 3'(BAT_MAX_WIN)) ? ib_req_bar_i : 3'h0;
    wire ib_upper = ib_bi[0] && ib_is64_q[ib_bi - 3'h1];
    wire ib_go = (ib_req_bar_i < 3'(BAT_MAX_WIN)) && (32'(ib_req_bar_i) < INBOUND_WINDOW_COUNT)
                 && ib_en_q[ib_bi] && !ib_upper;
    wire [BAT_PCIE_AW-1:0] ib_mask = (64'h1 << ib_size_q[ib_bi]) - 64'h1;
    wire [BAT_PCIE_AW-1:0] ib_full = (ib_trans_q[ib_bi] & ~ib_mask) | (ib_req_addr_i & ib_mask);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ib_rsp_valid_o <= 1'b0;
            ib_rsp_addr_o <= BAT_ZERO64[BAT_AXI_AW-1:0];
            ib_rsp_err_o <= 1'b0;
        end else if (ce_i) begin
            ib_rsp_valid_o <= ib_req_valid_i;
            if (ib_req_valid_i) begin
                ib_rsp_err_o <= !ib_go;
                ib_rsp_addr_o <= ib_go ? ib_full[BAT_AXI_AW-1:0] : BAT_ZERO64[BAT_AXI_AW-1:0];
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    wire ob_take = ce_i && ob_req_valid_i;

    a_out_wide: assert property (ob_take && |ob_hit && |sel_paddr[63:32] |=> ob_rsp_is64_o && !ob_rsp_slverr_o)
        else $error("wide translation not flagged 64-bit");
    a_out_narrow: assert property (ob_take && |ob_hit && sel_paddr[63:32] == 32'h0
        |=> !ob_rsp_is64_o && ob_rsp_addr_o[63:32] == 32'h0)
        else $error("narrow translation flagged 64-bit");
    a_out_offset: assert property (ob_take && |ob_hit
        |=> (ob_rsp_addr_o[11:0] == $past(ob_req_addr_i[11:0])))
        else $error("outbound offset not kept");
    a_in_offset: assert property (ce_i && ib_req_valid_i && ib_go
        |=> ib_rsp_addr_o[11:0] == $past(ib_req_addr_i[11:0]) && !ib_rsp_err_o)
        else $error("inbound offset not kept");
    a_in_upper_half: assert property (ce_i && ib_req_valid_i && ib_upper |=> ib_rsp_valid_o && ib_rsp_err_o)
        else $error("upper half BAR used alone");
    a_dir_apart: assert property (apb_wr && ib_ok |=> $stable(ob_trans_q[0]) && $stable(ob_en_q))
        else $error("inbound write changed outbound setup");
    a_out_miss: assert property (ob_take && !(|ob_hit) |=> ob_rsp_valid_o && ob_rsp_slverr_o)
        else $error("miss not answered with slave error");
    a_count_limit: assert property (ob_rsp_valid_o && !ob_rsp_slverr_o
        |-> 32'(ob_rsp_window_o) < OUTBOUND_WINDOW_COUNT && ob_rsp_window_o < 3'(BAT_MAX_WIN))
        else $error("hit on window beyond count");
    a_enable_gate: assert property (ob_take && !ob_en_q[1] |=> ob_rsp_slverr_o || ob_rsp_window_o != 3'h1)
        else $error("disabled window hit");
    a_trans_write: assert property (apb_wr && ob_ok && ob_idx == 3'h0 && ob_word == BAT_OB_W_TRANS_LO
        && pstrb_i == 4'hf |=> ob_trans_q[0][31:0] == $past(pwdata_i))
        else $error("translation write lost");

    c_wide_hit: cover property (ob_rsp_valid_o && ob_rsp_is64_o);
    c_narrow_hit: cover property (ob_rsp_valid_o && !ob_rsp_is64_o && !ob_rsp_slverr_o);
    c_miss: cover property (ob_rsp_valid_o && ob_rsp_slverr_o);
    c_inbound: cover property (ib_rsp_valid_o && !ib_rsp_err_o);
endmodule

/* File: pkg/bat_pkg.sv */
// Constants shared by the address translation unit and its window matcher.
// Assumes a 32-bit APB register port and a 48-bit local address space.
package bat_pkg;

    // ==========================================================
    // Widths and limits
    localparam int BAT_MAX_WIN = 6;
    localparam int BAT_AXI_AW = 48;
    localparam int BAT_PCIE_AW = 64;
    localparam int BAT_APB_AW = 12;
    localparam int BAT_IB_SIZE_W = 6;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [3:0] BAT_OB_REGION = 4'h0;
    localparam logic [3:0] BAT_IB_REGION = 4'h1;
    localparam logic [11:0] BAT_CTRL_OFS = 12'h200;
    localparam logic [11:0] BAT_STAT_OFS = 12'h204;

    // Word index inside one outbound window block (stride 0x20)
    localparam logic [2:0] BAT_OB_W_BASE_LO = 3'h0;
    localparam logic [2:0] BAT_OB_W_BASE_HI = 3'h1;
    localparam logic [2:0] BAT_OB_W_TOP_LO = 3'h2;
    localparam logic [2:0] BAT_OB_W_TOP_HI = 3'h3;
    localparam logic [2:0] BAT_OB_W_TRANS_LO = 3'h4;
    localparam logic [2:0] BAT_OB_W_TRANS_HI = 3'h5;
    localparam logic [2:0] BAT_OB_W_COUNT = 3'h6;

    // Word index inside one inbound BAR block (stride 0x10)
    localparam logic [1:0] BAT_IB_W_TRANS_LO = 2'h0;
    localparam logic [1:0] BAT_IB_W_TRANS_HI = 2'h1;
    localparam logic [1:0] BAT_IB_W_SIZE = 2'h2;
    localparam logic [1:0] BAT_IB_W_FLAGS = 2'h3;

    // ==========================================================
    // Field positions
    localparam int BAT_CTRL_OB_EN_POS = 0;
    localparam int BAT_CTRL_IB_EN_POS = 8;
    localparam int BAT_STAT_MISS_POS = 8;
    localparam int BAT_IB_FLAG_64_POS = 0;

    // ==========================================================
    // Reset values
    localparam logic [BAT_MAX_WIN-1:0] BAT_EN_RST = 6'h00;
    localparam logic [BAT_IB_SIZE_W-1:0] BAT_IB_SIZE_RST = 6'h0c;
    localparam logic [63:0] BAT_ZERO64 = 64'h0;

endpackage

/* File: sim/bar_address_translation_tb.sv */
// Self-checking bench for the address translation unit: APB setup, queued translation checks.
// Assumes bat_pkg, bat_top and bat_req_model are compiled before this file.
`timescale 1ns/10ps
module bar_address_translation_tb;
    import bat_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata, r, rs = 32'd74;
    logic pready, pslverr, e, ob_v, ib_v, ob_rv, ob_is64, ob_err, ib_rv, ib_err;
    logic [47:0] ob_a, ib_ra, off;
    logic [63:0] ib_a, ob_ra;
    logic [2:0] ib_b, ob_win;
    logic [68:0] obq[$];
    logic [48:0] ibq[$];
    logic [68:0] oe;
    logic [48:0] ie;
    int checks = 0;
    int miscompares = 0;
    int i;
    localparam logic [31:0] all_m = 32'hffff_ffff;
    // Power-of-two windows of 4 KB or more, translation zero below the window size
    logic [47:0] wb[6] = '{48'h1234_0000, 48'habcd_e000, 48'hfe00_0000, 48'h0, 48'h10_0000_0000,
        48'h8000_0000_0000};
    logic [47:0] wt[6] = '{48'h1234_ffff, 48'habcd_ffff, 48'hffff_ffff, 48'hfff, 48'h10_0000_1fff,
        48'h8000_0000_ffff};
    logic [63:0] wx[6] = '{64'h5671_0000, 64'h5000_0000_fedc_0000, 64'h4000_0000,
        64'h6000_0000_8765_4000, 64'h2000, 64'h7_0000_0000};
    always #2.5 clk = ~clk;
    bat_top #(.OUTBOUND_WINDOW_COUNT(6), .INBOUND_WINDOW_COUNT(6)) dut (
        .clk_i(clk), .srst_i(srst), .ce_i(ce), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .ob_req_valid_i(ob_v), .ob_req_addr_i(ob_a), .ob_rsp_valid_o(ob_rv),
        .ob_rsp_addr_o(ob_ra), .ob_rsp_is64_o(ob_is64), .ob_rsp_slverr_o(ob_err),
        .ob_rsp_window_o(ob_win), .ib_req_valid_i(ib_v), .ib_req_bar_i(ib_b), .ib_req_addr_i(ib_a),
        .ib_rsp_valid_o(ib_rv), .ib_rsp_addr_o(ib_ra), .ib_rsp_err_o(ib_err)
    );
    bat_req_model m (.clk_i(clk), .ob_valid_o(ob_v), .ob_addr_o(ob_a), .ib_valid_o(ib_v),
        .ib_bar_o(ib_b), .ib_addr_o(ib_a));
    // ==========================================================
    // Comparison and bus tasks
    task automatic chk_ob(input logic [68:0] g, input logic [68:0] x);
        checks++;
        if (g !== x) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic chk_ib(input logic [48:0] g, input logic [48:0] x);
        chk_ob({20'h0, g}, {20'h0, x});
    endtask
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
        chk_ob({37'h0, g}, {37'h0, x});
    endtask
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic [31:0] mk, input logic xe);
        apb(1'b0, a, 32'h0);
        chk_reg(r & mk, x);
        chk_reg({31'h0, e}, {31'h0, xe});
    endtask
    task automatic ob(input logic [47:0] a, input logic [68:0] x);
        obq.push_back(x);
        m.ob_send(a);
    endtask
    task automatic ib(input logic [2:0] b, input logic [63:0] a, input logic [48:0] x);
        ibq.push_back(x);
        m.ib_send(b, a);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Monitor: every response pulse takes the oldest note
    always @(negedge clk) begin
        if (ob_rv !== 1'b0) begin
            oe = (obq.size() > 0) ? obq.pop_front() : '1;
            chk_ob({ob_ra, ob_is64, ob_err, ob_win}, oe);
        end
        if (ib_rv !== 1'b0) begin
            ie = (ibq.size() > 0) ? ibq.pop_front() : '1;
            chk_ib({ib_ra, ib_err}, ie);
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rdc(12'h200, 32'h0, all_m, 1'b0);
        rdc(12'h204, 32'h0, all_m, 1'b0);
        rdc(12'h108, 32'hc, all_m, 1'b0);
        rdc(12'h018, 32'h0, all_m, 1'b1);
        done("reset");
        for (i = 0; i < 6; i++) begin
            wr_win(i);
        end
        pstrb <= 4'h1;
        apb(1'b1, 12'h200, all_m);
        pstrb <= 4'hf;
        rdc(12'h200, 32'h3f, 32'h3f3f, 1'b0);
        ob(48'h1234_0abc, {64'h5671_0abc, 1'b0, 1'b0, 3'd0});
        ob(48'habcd_f123, {64'h5000_0000_fedc_1123, 1'b1, 1'b0, 3'd1});
        ob(48'hfffe_dcba, {64'h41fe_dcba, 1'b0, 1'b0, 3'd2});
        ob(48'h71, {64'h6000_0000_8765_4071, 1'b1, 1'b0, 3'd3});
        for (int k = 0; k < 12; k++) begin
            i = k % 6;
            off = {16'h0, xs()} & (wt[i] - wb[i]);
            ob(wb[i] + off, {(wx[i] & ~{16'h0, wt[i] - wb[i]}) | {16'h0, off}, wx[i][63:32] != 32'h0,
                1'b0, 3'(i)});
        end
        ob(48'h1235_0000, {64'h0, 1'b0, 1'b1, 3'h0});
        ob(48'h1233_ffff, {64'h0, 1'b0, 1'b1, 3'h0});
        m.idle();
        done("outbound");
        rdc(12'h204, 32'h0002_0100, 32'hffff_0100, 1'b0);
        apb(1'b1, 12'h204, 32'h100);
        rdc(12'h204, 32'h0, 32'h100, 1'b0);
        apb(1'b1, 12'h200, 32'h3d);
        ob(48'habcd_e010, {64'h0, 1'b0, 1'b1, 3'h0});
        m.idle();
        apb(1'b1, 12'h014, 32'h1);
        ob(48'h1234_0abc, {64'h1_5671_0abc, 1'b1, 1'b0, 3'd0});
        m.idle();
        done("window control");
        // Aperture 32 KB and 32 MB, translation clear below the aperture and above bit 47
        apb(1'b1, 12'h100, 32'h1234_0000);
        apb(1'b1, 12'h108, 32'hf);
        apb(1'b1, 12'h10c, 32'h1);
        apb(1'b1, 12'h120, 32'hfe00_0000);
        apb(1'b1, 12'h128, 32'h19);
        apb(1'b1, 12'h12c, 32'h1);
        apb(1'b1, 12'h200, 32'h3f3f);
        ib(3'd0, 64'h2000_0000_abcd_fff4, {48'h1234_7ff4, 1'b0});
        ib(3'd2, 64'ha000_0000_1235_fedc, {48'hfe35_fedc, 1'b0});
        ib(3'd1, 64'h0, {48'h0, 1'b1});
        ib(3'd3, 64'h10, {48'h0, 1'b1});
        ib(3'd4, 64'h5_0000_0123, {48'h123, 1'b0});
        ib(3'd6, 64'h0, {48'h0, 1'b1});
        m.idle();
        ob(48'habcd_f123, {64'h5000_0000_fedc_1123, 1'b1, 1'b0, 3'd1});
        ob(48'h71, {64'h6000_0000_8765_4071, 1'b1, 1'b0, 3'd3});
        m.idle();
        // Enable low: requests are not taken, so no response and no miss count
        ce <= 1'b0;
        m.ob_send(48'h1235_0000);
        chk_reg({31'h0, pready}, 32'h0);
        m.ib_send(3'd0, 64'h0);
        ce <= 1'b1;
        m.idle();
        rdc(12'h204, 32'h0003_0100, 32'hffff_0100, 1'b0);
        repeat (3) @(posedge clk);
        chk_reg(32'(obq.size() + ibq.size()), 32'h0);
        done("inbound");
        report_and_stop();
    end
    task automatic wr_win(input int n);
        apb(1'b1, 12'(n * 32), wb[n][31:0]);
        apb(1'b1, 12'(n * 32 + 4), {16'h0, wb[n][47:32]});
        apb(1'b1, 12'(n * 32 + 8), wt[n][31:0]);
        apb(1'b1, 12'(n * 32 + 12), {16'h0, wt[n][47:32]});
        apb(1'b1, 12'(n * 32 + 16), wx[n][31:0]);
        apb(1'b1, 12'(n * 32 + 20), wx[n][63:32]);
    endtask
endmodule

/* File: sim/bat_req_model.sv */
// Requester model: local bus master on the outbound port, PCIe link on the inbound port.
// Assumes every task is entered right after a rising edge of clk_i.
`timescale 1ns/10ps
module bat_req_model (
    input wire logic clk_i,
    output logic ob_valid_o,
    output logic [47:0] ob_addr_o,
    output logic ib_valid_o,
    output logic [2:0] ib_bar_o,
    output logic [63:0] ib_addr_o
);
    initial begin
        ob_valid_o = 1'b0;
        ob_addr_o = 48'h0;
        ib_valid_o = 1'b0;
        ib_bar_o = 3'h0;
        ib_addr_o = 64'h0;
    end
    // ==========================================================
    // Requests: one edge each, back to back when called in a row
    task automatic ob_send(input logic [47:0] a);
        ob_valid_o <= 1'b1;
        ob_addr_o <= a;
        @(posedge clk_i);
    endtask
    task automatic ib_send(input logic [2:0] b, input logic [63:0] a);
        ib_valid_o <= 1'b1;
        ib_bar_o <= b;
        ib_addr_o <= a;
        @(posedge clk_i);
    endtask
    // Released address lines show the inverse, so a stale address never passes for a live one
    task automatic idle();
        ob_valid_o <= 1'b0;
        ob_addr_o <= ~ob_addr_o;
        ib_valid_o <= 1'b0;
        ib_addr_o <= ~ib_addr_o;
        @(posedge clk_i);
    endtask
endmodule
